// ===== hw/mode_pkg.sv
// mode control bank constants: offsets, bit positions, reset values
// assumes a 16-bit register port with byte addresses as printed
package mode_pkg;
    localparam logic [15:0] SET_OFS = 16'h1032;
    localparam logic [15:0] CLEAR_OFS = 16'h1034;
    localparam logic [15:0] TEST_ADDR_OFS = 16'h1036;
    localparam logic [15:0] TEST_UPPER_OFS = 16'h1038;
    localparam logic [15:0] TEST_LOWER_OFS = 16'h103a;
    localparam int MEM_TEST_BIT = 0;
    localparam int OFFLINE_BIT = 1;
    localparam int CLEAR_DATA_BIT = 2;
    localparam int OVER_RANGE_BIT = 3;
    localparam int LOW_THRESH_BIT = 4;
    localparam int VALID_CTRL_BIT = 5;
    localparam int ACQUISITION_TEST_BIT = 6;
    localparam int SLIDE_ON_BIT = 7;
    localparam int THRESH_RES_BIT = 8;
    localparam int START_STOP_BIT = 10;
    localparam int AUTOADV_BIT = 11;
    localparam int BLANK_FRAME_BIT = 12;
    localparam int SLIDE_SUB_BIT = 13;
    localparam int COUNT_ALL_BIT = 14;
    localparam logic [15:0] MODE_RESET = 16'h4880;
    localparam logic [15:0] MODE_WRITABLE = 16'h7dff;
    localparam int ADDR_W = 11;
endpackage

// ===== hw/set_clear_bit.sv
// one mode bit with write-one-to-set and write-one-to-clear strobes
// assumes synchronous strobes on mclk_in
`timescale 1ns/1ps
module set_clear_bit #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic clear_in,
    output logic bit_out
);
    logic bit_q;
    logic bit_d;
    always_comb begin
        bit_d = bit_q;
        if (set_in) begin
            bit_d = 1'b1; // R1
        end else if (clear_in) begin
            bit_d = 1'b0; // R3
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_q <= RESET_VAL; // R26
        end else begin
            bit_q <= bit_d;
        end
    end
    assign bit_out = bit_q;
endmodule // set_clear_bit

// ===== hw/test_word_path.sv
// memory-test write path: address, held upper half, commit on lower half
// assumes decoded one-cycle write strobes
`timescale 1ns/1ps
module test_word_path #(
    parameter int ADDR_W = 11
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic mem_test_in,
    input wire logic addr_wr_in,
    input wire logic upper_wr_in,
    input wire logic lower_wr_in,
    input wire logic [15:0] wdata_in,
    output logic mem_we_out,
    output logic [ADDR_W-1:0] mem_addr_out,
    output logic [31:0] mem_data_out
);
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [15:0] upper_q, upper_d;
    logic we_q, we_d;
    logic [31:0] data_q, data_d;
    always_comb begin
        addr_d = addr_q;
        upper_d = upper_q;
        we_d = 1'b0;
        data_d = data_q;
        if (addr_wr_in) begin
            addr_d = wdata_in[ADDR_W-1:0];
        end
        if (upper_wr_in) begin
            upper_d = wdata_in; // R20
        end
        if (lower_wr_in && mem_test_in) begin
            we_d = 1'b1; // R6
            data_d = {upper_q, wdata_in}; // R20
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_q <= '0; // R26
            upper_q <= 16'h0000;
            we_q <= 1'b0;
            data_q <= 32'h0000_0000;
        end else begin
            addr_q <= addr_d;
            upper_q <= upper_d;
            we_q <= we_d;
            data_q <= data_d;
        end
    end
    assign mem_we_out = we_q;
    assign mem_addr_out = addr_q;
    assign mem_data_out = data_q;
endmodule // test_word_path

// ===== hw/mode_control_set_clear_bank.sv
// operation-mode register with set/clear ports and memory-test write path
// assumes a synchronous 16-bit register port; one-cycle wr/rd strobes
//
// Summary of operation
// R1 - writing ones to set port sets those mode bits; zeros do nothing
// R2 - reading set port returns all mode bits
// R3 - writing ones to clear port clears those bits; same layout as set port
// R4 - data-reset request is bit 2, cleared by writing 0x4 to clear port
// R5 - software keeps reserved bits unchanged
// R6 - bit 0 selects memory test; when one host writes output memory
// R7 - converter-halt bit one takes conversion controller offline
// R8 - data-reset bit one clears data, pointers, event counter, peaks
// R9 - overflow-check-disable one stores every conversion, else non-overflow only
// R10 - zero-suppression-disable one stores all data, else above threshold
// R11 - common stop: validity-check-disable zero stores only valid data
// R12 - acquisition-test bit one fills buffer from test-event FIFO
// R13 - sliding scale on by default; off drives stored constant
// R14 - threshold-resolution bit selects threshold times 16 or times 2
// R15 - timing reference: zero common start, one common stop
// R16 - auto-advance one advances read pointer on readout, else on increment writes
// R17 - blank framing one writes header and end-of-block for empty events
// R18 - sliding-subtract disable one bypasses subtraction, testing only
// R19 - count-all-triggers one counts every trigger, else accepted only
// R20 - upper half held; lower-half write commits 32-bit word at test address
// R21 - software writes mode, address, upper half, then lower half
// R22 - software keeps test read and write addresses different
// R23 - read-pointer auto-advance at bit 11
// R24 - count-all-triggers at bit 14
// R25 - acquisition-test select at bit 6
// R26 - reset loads documented defaults and clears test registers
`timescale 1ns/1ps
module mode_control_set_clear_bank #(
    parameter int ADDR_W = mode_pkg::ADDR_W
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic mem_test_out,
    output logic converter_halt_out,
    output logic data_reset_out,
    output logic store_overflowed_out,
    output logic store_below_threshold_out,
    output logic store_invalid_out,
    output logic acquisition_test_select_out,
    output logic sliding_scale_on_out,
    output logic threshold_resolution_select_out,
    output logic common_stop_out,
    output logic read_pointer_autoadvance_out,
    output logic blank_event_framing_out,
    output logic sliding_subtract_off_out,
    output logic count_all_triggers_out,
    output logic test_mem_we_out,
    output logic [ADDR_W-1:0] test_mem_addr_out,
    output logic [31:0] test_mem_data_out
);
    logic set_hit, clear_hit, addr_hit, upper_hit, lower_hit;
    logic [15:0] mode;
    logic [15:0] set_mask, clear_mask;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    // one write strobe per access; unmapped addresses raise none
    always_comb begin
        set_hit = 1'b0;
        clear_hit = 1'b0;
        addr_hit = 1'b0;
        upper_hit = 1'b0;
        lower_hit = 1'b0;
        if (addr_in == mode_pkg::SET_OFS) begin
            set_hit = wr_in;
        end else if (addr_in == mode_pkg::CLEAR_OFS) begin
            clear_hit = wr_in;
        end else if (addr_in == mode_pkg::TEST_ADDR_OFS) begin
            addr_hit = wr_in;
        end else if (addr_in == mode_pkg::TEST_UPPER_OFS) begin
            upper_hit = wr_in;
        end else if (addr_in == mode_pkg::TEST_LOWER_OFS) begin
            lower_hit = wr_in;
        end
    end

    // writes to reserved positions are dropped, so they always read zero
    always_comb begin
        set_mask = 16'h0000;
        clear_mask = 16'h0000;
        if (set_hit) begin
            set_mask = wdata_in & mode_pkg::MODE_WRITABLE; // R1
        end
        if (clear_hit) begin
            clear_mask = wdata_in & mode_pkg::MODE_WRITABLE; // R3
        end
    end

    // reserved positions 9 and 15 have no storage
    assign mode[9] = 1'b0;
    assign mode[15] = 1'b0;

    // test and data-reset controls
    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::MEM_TEST_BIT])
    ) u_mem_test (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::MEM_TEST_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::MEM_TEST_BIT]), // R3
        .bit_out(mode[mode_pkg::MEM_TEST_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::OFFLINE_BIT])
    ) u_converter_halt (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::OFFLINE_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::OFFLINE_BIT]), // R3
        .bit_out(mode[mode_pkg::OFFLINE_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::CLEAR_DATA_BIT])
    ) u_data_reset (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::CLEAR_DATA_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::CLEAR_DATA_BIT]), // R3
        .bit_out(mode[mode_pkg::CLEAR_DATA_BIT])
    );

    // storage filters
    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::OVER_RANGE_BIT])
    ) u_overflow_check_off (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::OVER_RANGE_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::OVER_RANGE_BIT]), // R3
        .bit_out(mode[mode_pkg::OVER_RANGE_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::LOW_THRESH_BIT])
    ) u_threshold_check_off (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::LOW_THRESH_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::LOW_THRESH_BIT]), // R3
        .bit_out(mode[mode_pkg::LOW_THRESH_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::VALID_CTRL_BIT])
    ) u_validity_check_off (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::VALID_CTRL_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::VALID_CTRL_BIT]), // R3
        .bit_out(mode[mode_pkg::VALID_CTRL_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::ACQUISITION_TEST_BIT])
    ) u_acquisition_test (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::ACQUISITION_TEST_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::ACQUISITION_TEST_BIT]), // R3
        .bit_out(mode[mode_pkg::ACQUISITION_TEST_BIT])
    );

    // conversion and timing controls
    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::SLIDE_ON_BIT])
    ) u_sliding_scale (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::SLIDE_ON_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::SLIDE_ON_BIT]), // R3
        .bit_out(mode[mode_pkg::SLIDE_ON_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::THRESH_RES_BIT])
    ) u_threshold_resolution (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::THRESH_RES_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::THRESH_RES_BIT]), // R3
        .bit_out(mode[mode_pkg::THRESH_RES_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::START_STOP_BIT])
    ) u_common_stop (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::START_STOP_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::START_STOP_BIT]), // R3
        .bit_out(mode[mode_pkg::START_STOP_BIT])
    );

    // readout and counting controls
    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::AUTOADV_BIT])
    ) u_autoadvance (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::AUTOADV_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::AUTOADV_BIT]), // R3
        .bit_out(mode[mode_pkg::AUTOADV_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::BLANK_FRAME_BIT])
    ) u_blank_framing (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::BLANK_FRAME_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::BLANK_FRAME_BIT]), // R3
        .bit_out(mode[mode_pkg::BLANK_FRAME_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::SLIDE_SUB_BIT])
    ) u_subtract_off (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::SLIDE_SUB_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::SLIDE_SUB_BIT]), // R3
        .bit_out(mode[mode_pkg::SLIDE_SUB_BIT])
    );

    set_clear_bit #(
        .RESET_VAL(mode_pkg::MODE_RESET[mode_pkg::COUNT_ALL_BIT])
    ) u_count_all (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(set_mask[mode_pkg::COUNT_ALL_BIT]), // R1
        .clear_in(clear_mask[mode_pkg::COUNT_ALL_BIT]), // R3
        .bit_out(mode[mode_pkg::COUNT_ALL_BIT])
    );

    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        // only the set port reads back; every other address returns zero
        if (rd_in) begin
            rvalid_d = 1'b1;
            rdata_d = 16'h0000;
            if (addr_in == mode_pkg::SET_OFS) begin
                rdata_d = mode; // R2
            end
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end
    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;

    assign mem_test_out = mode[mode_pkg::MEM_TEST_BIT]; // R6
    assign converter_halt_out = mode[mode_pkg::OFFLINE_BIT]; // R7
    assign data_reset_out = mode[mode_pkg::CLEAR_DATA_BIT]; // R4 R8
    assign store_overflowed_out = mode[mode_pkg::OVER_RANGE_BIT]; // R9
    assign store_below_threshold_out = mode[mode_pkg::LOW_THRESH_BIT]; // R10
    // validity check only applies in common stop mode
    assign store_invalid_out = mode[mode_pkg::VALID_CTRL_BIT]
        || !mode[mode_pkg::START_STOP_BIT]; // R11
    assign acquisition_test_select_out = mode[mode_pkg::ACQUISITION_TEST_BIT]; // R12 R25
    assign sliding_scale_on_out = mode[mode_pkg::SLIDE_ON_BIT]; // R13
    assign threshold_resolution_select_out = mode[mode_pkg::THRESH_RES_BIT]; // R14
    assign common_stop_out = mode[mode_pkg::START_STOP_BIT]; // R15
    assign read_pointer_autoadvance_out = mode[mode_pkg::AUTOADV_BIT]; // R16 R23
    assign blank_event_framing_out = mode[mode_pkg::BLANK_FRAME_BIT]; // R17
    assign sliding_subtract_off_out = mode[mode_pkg::SLIDE_SUB_BIT]; // R18
    assign count_all_triggers_out = mode[mode_pkg::COUNT_ALL_BIT]; // R19 R24

    test_word_path #(
        .ADDR_W(ADDR_W)
    ) u_test (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .mem_test_in(mode[mode_pkg::MEM_TEST_BIT]),
        .addr_wr_in(addr_hit),
        .upper_wr_in(upper_hit),
        .lower_wr_in(lower_hit), // R20
        .wdata_in(wdata_in),
        .mem_we_out(test_mem_we_out),
        .mem_addr_out(test_mem_addr_out),
        .mem_data_out(test_mem_data_out)
    );
endmodule // mode_control_set_clear_bank

// ===== tb/mode_bank_properties.sv
// checker for the mode bank ports: set, clear, readback and test-word commit
// assumes one-cycle strobes sampled on the rising clock edge
`timescale 1ns/1ps
module mode_bank_checker (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic mem_test_out,
    input wire logic data_reset_out,
    input wire logic count_all_triggers_out,
    input wire logic test_mem_we_out,
    input wire logic [31:0] test_mem_data_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire ws = wr_in && addr_in == mode_pkg::SET_OFS;
    wire wc = wr_in && addr_in == mode_pkg::CLEAR_OFS;
    wire wl = wr_in && addr_in == mode_pkg::TEST_LOWER_OFS;
    a_set_one_bit: assert property (ws && wdata_in[0] |=> mem_test_out)
        else $error("set write missed");
    a_zero_holds_bit: assert property (ws && !wdata_in[14] |=> $stable(count_all_triggers_out))
        else $error("zero bit changed");
    a_clear_data_reset: assert property (wc && wdata_in[2] |=> !data_reset_out)
        else $error("clear write missed");
    a_readback_mode: assert property (rd_in && !wr_in && addr_in == mode_pkg::SET_OFS |=>
        rvalid_out && rdata_out[0] == mem_test_out && rdata_out[14] == count_all_triggers_out)
        else $error("readback wrong");
    a_rvalid_cause: assert property (rvalid_out |-> $past(rd_in))
        else $error("stray rvalid");
    a_commit_gated: assert property (wl && !mem_test_out |=> !test_mem_we_out)
        else $error("commit outside test mode");
    a_commit_word: assert property (wl && mem_test_out |=>
        test_mem_we_out && test_mem_data_out[15:0] == $past(wdata_in))
        else $error("commit wrong");
    a_commit_cause: assert property (test_mem_we_out |-> $past(wl) && $past(mem_test_out))
        else $error("stray commit");
    c_commit: cover property (test_mem_we_out);
    c_read: cover property (rvalid_out);
    c_clear: cover property (wc && wdata_in[2]);
endmodule // mode_bank_checker

bind mode_control_set_clear_bank mode_bank_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .mem_test_out(mem_test_out),
    .data_reset_out(data_reset_out), .count_all_triggers_out(count_all_triggers_out),
    .test_mem_we_out(test_mem_we_out), .test_mem_data_out(test_mem_data_out));

// ===== tb/tb.sv
// self-checking bench for the mode bank: register port tasks and sequences
// assumes one-cycle strobes and read data registered one cycle later
`timescale 1ns/1ps
module tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [15:0] wdata_in = 16'h0000;
    logic [15:0] rdata_out, exp_mode;
    logic [10:0] test_mem_addr_out;
    logic [31:0] test_mem_data_out;
    logic rvalid_out, mem_test_out, converter_halt_out, data_reset_out, store_overflowed_out;
    logic store_below_threshold_out, store_invalid_out, acquisition_test_select_out;
    logic sliding_scale_on_out, threshold_resolution_select_out, common_stop_out;
    logic read_pointer_autoadvance_out, blank_event_framing_out, sliding_subtract_off_out;
    logic count_all_triggers_out, test_mem_we_out;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    wire [15:0] obs = {1'b0, count_all_triggers_out, sliding_subtract_off_out,
        blank_event_framing_out, read_pointer_autoadvance_out, common_stop_out, 1'b0,
        threshold_resolution_select_out, sliding_scale_on_out, acquisition_test_select_out,
        store_invalid_out, store_below_threshold_out, store_overflowed_out, data_reset_out,
        converter_halt_out, mem_test_out};
    mode_control_set_clear_bank DUT (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .rvalid_out(rvalid_out), .mem_test_out(mem_test_out),
        .converter_halt_out(converter_halt_out), .data_reset_out(data_reset_out),
        .store_overflowed_out(store_overflowed_out),
        .store_below_threshold_out(store_below_threshold_out),
        .store_invalid_out(store_invalid_out),
        .acquisition_test_select_out(acquisition_test_select_out),
        .sliding_scale_on_out(sliding_scale_on_out),
        .threshold_resolution_select_out(threshold_resolution_select_out),
        .common_stop_out(common_stop_out),
        .read_pointer_autoadvance_out(read_pointer_autoadvance_out),
        .blank_event_framing_out(blank_event_framing_out),
        .sliding_subtract_off_out(sliding_subtract_off_out),
        .count_all_triggers_out(count_all_triggers_out), .test_mem_we_out(test_mem_we_out),
        .test_mem_addr_out(test_mem_addr_out), .test_mem_data_out(test_mem_data_out));
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge mclk_in);
        wr_in = 1'b0;
    endtask
    // read of the set port; outputs compared too, bit 5 merged with timing mode
    task automatic mode_chk;
        @(negedge mclk_in);
        addr_in = mode_pkg::SET_OFS;
        rd_in = 1'b1;
        @(negedge mclk_in);
        rd_in = 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid_out});
        chk("rdata", {16'h0, exp_mode}, {16'h0, rdata_out});
        chk("outputs", {exp_mode[15:6], exp_mode[5] | ~exp_mode[10], exp_mode[4:0]}, obs);
    endtask
    task automatic setb(input logic [15:0] d);
        wr(mode_pkg::SET_OFS, d);
        exp_mode = exp_mode | d;
    endtask
    task automatic clrb(input logic [15:0] d);
        wr(mode_pkg::CLEAR_OFS, d);
        exp_mode = exp_mode & ~d;
    endtask
    initial begin
        exp_mode = 16'h4880;
        repeat (20) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 1'b0;
        mode_chk();
        for (int i = 0; i < 15; i++) begin
            if (i != 9) begin
                setb(16'h0001 << i);
                mode_chk();
                clrb(16'h0001 << i);
                mode_chk();
            end
        end
        setb(16'h0005);
        setb(16'h0000);
        mode_chk();
        clrb(16'h0005);
        wr(16'h1030, 16'h7dff);
        mode_chk();
        wr(mode_pkg::TEST_ADDR_OFS, 16'h0123);
        wr(mode_pkg::TEST_UPPER_OFS, 16'hbeef);
        wr(mode_pkg::TEST_LOWER_OFS, 16'h1234);
        chk("we gated", 32'h0, {31'h0, test_mem_we_out});
        setb(16'h0001);
        wr(mode_pkg::TEST_LOWER_OFS, 16'h5678);
        chk("we", 32'h1, {31'h0, test_mem_we_out});
        chk("word", 32'hbeef5678, test_mem_data_out);
        chk("addr", 32'h123, {21'h0, test_mem_addr_out});
        wr(mode_pkg::TEST_UPPER_OFS, 16'hcafe);
        wr(mode_pkg::TEST_LOWER_OFS, 16'h9abc);
        chk("word2", 32'hcafe9abc, test_mem_data_out);
        rst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        exp_mode = 16'h4880;
        chk("word rst", 32'h0, test_mem_data_out);
        mode_chk();
        report_and_stop();
    end
endmodule // tb
